//--- src/cfpwm_pkg.sv
// constants and carrier types for the coded-frequency pwm output channel
// assumes a single 50 MHz clock shared by every user of this package
`default_nettype none

package cfpwm_pkg;

    // clock period in ns (50 MHz)
    localparam int unsigned CLK_PERIOD_NS = 20;

    // number of frequency selection codes, highest code, coarse range start
    localparam int unsigned CODE_COUNT = 25;
    localparam logic [4:0] CODE_MAX = 5'h18;
    localparam logic [4:0] CODE_COARSE_FIRST = 5'h14;
    // first code unsupported on a medium-speed channel
    localparam logic [4:0] CODE_MEDIUM_LIMIT = 5'h15;

    // duty limits and step counts for the fine and coarse ranges
    localparam logic [9:0] DUTY_MAX_FINE = 10'h3e7;
    localparam logic [9:0] DUTY_MAX_COARSE = 10'h3de;
    localparam logic [9:0] STEPS_FINE = 10'h3e8;
    localparam logic [9:0] STEPS_COARSE = 10'h064;
    // coarse duty is given in tenths of a percent, used in whole percent
    localparam logic [9:0] COARSE_UNIT = 10'h00a;
    localparam logic [9:0] COARSE_ROUND = 10'h005;

    // output period per code, in units of 10 us, as printed
    localparam int unsigned PERIOD_10US [CODE_COUNT] = '{
        66667, 50251, 24570, 16393, 12285, 10235, 5120, 2048, 1024, 496,
        248, 200, 144, 96, 80, 64, 48, 32, 16, 8,
        6, 5, 4, 3, 2};

    // clock cycles per duty step; floor, but never below one cycle
    function automatic int unsigned calc_step(input int unsigned idx);
        int unsigned steps;
        int unsigned cyc;
        steps = (idx >= 20) ? 100 : 1000;
        cyc = (PERIOD_10US[idx] * 10000) / (CLK_PERIOD_NS * steps);
        return (cyc == 0) ? 1 : cyc;
    endfunction : calc_step

    function automatic int unsigned calc_step_entry(input int unsigned idx);
        return calc_step(idx);
    endfunction : calc_step_entry

    // prescaler reload table, one entry per code
    localparam int unsigned STEP_CYCLES [CODE_COUNT] = '{
        calc_step_entry(0), calc_step_entry(1), calc_step_entry(2),
        calc_step_entry(3), calc_step_entry(4), calc_step_entry(5),
        calc_step_entry(6), calc_step_entry(7), calc_step_entry(8),
        calc_step_entry(9), calc_step_entry(10), calc_step_entry(11),
        calc_step_entry(12), calc_step_entry(13), calc_step_entry(14),
        calc_step_entry(15), calc_step_entry(16), calc_step_entry(17),
        calc_step_entry(18), calc_step_entry(19), calc_step_entry(20),
        calc_step_entry(21), calc_step_entry(22), calc_step_entry(23),
        calc_step_entry(24)};

    // prescaler width: largest entry is about 33k cycles
    localparam int unsigned PRE_W = 16;

    // settings carried together: frequency code and duty value
    typedef struct packed {
        logic [4:0] code;
        logic [9:0] duty;
    } cfpwm_setting_type;

    // channel state, one-hot
    typedef enum logic [1:0] {
        CFPWM_IDLE = 2'b01,
        CFPWM_RUN = 2'b10
    } cfpwm_state_type;

endpackage : cfpwm_pkg

`default_nettype wire

//--- src/cfpwm_channel.sv
// one pwm output channel with coded frequency and checked duty value
// assumes: enable pin is asynchronous, all other inputs come from clk logic,
// start command is a one-cycle pulse from the controlling logic
`default_nettype none

// Operation
// - code 0..24 selects 1.5 Hz..50 kHz, 0..20 only on a medium-speed channel
// - codes 0..19: duty 0..999 tenths percent
// - codes 20..24: duty 0..990, 1% steps
// - running out-of-range duty clamps to maximum
// - out-of-range duty at start gives error
// - output only while enable input asserted
module cfpwm_channel
    import cfpwm_pkg::*;
#(
    parameter bit MEDIUM_SPEED_CHANNEL = 1'b0 // medium-speed channel of the variant
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic pwm_enable_input,
    input wire logic channel_configured_pwm,
    input wire logic pwm_start_command,
    input wire cfpwm_setting_type pwm_setting,
    output logic pwm_output_pin,
    output logic pwm_running,
    output logic operation_error,
    output logic duty_clamped
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // code belongs to the coarse 100-step range
    function automatic logic is_coarse(input logic [4:0] code);
        return code >= CODE_COARSE_FIRST;
    endfunction : is_coarse

    // duty ceiling for a code
    function automatic logic [9:0] duty_ceiling(input logic [4:0] code);
        return is_coarse(code) ? DUTY_MAX_COARSE : DUTY_MAX_FINE;
    endfunction : duty_ceiling

    // code usable on this channel at all
    function automatic logic code_ok(input logic [4:0] code);
        if (code > CODE_MAX) begin
            return 1'b0;
        end else if (MEDIUM_SPEED_CHANNEL && code >= CODE_MEDIUM_LIMIT) begin
            return 1'b0;
        end else begin
            return 1'b1;
        end
    endfunction : code_ok

    ////////////////////////////////////////////////////////////////////////
    // enable pin synchroniser

    logic en_meta; // first stage, read only by en_sync
    logic en_sync; // safe copy of the enable pin

    // two flops before anything looks at the pin
    always_ff @(posedge clk) begin
        if (srst) begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
        end else begin
            en_meta <= pwm_enable_input;
            en_sync <= en_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state and settings

    cfpwm_state_type state; // idle or running
    logic [4:0] act_code; // code in effect this period
    logic [9:0] act_level; // high steps in effect this period
    logic [PRE_W-1:0] pre_cnt; // clocks left in this step
    logic [9:0] step_cnt; // step within the period
    logic step_tick; // prescaler wrapped
    logic boundary; // last step of the period ends now
    logic [9:0] act_steps; // steps per period for the active code
    logic start_ok; // start request passes every check
    logic keep_on; // running conditions still hold
    logic [9:0] req_ceiling; // ceiling for the requested code
    logic req_over; // requested duty out of range
    logic [9:0] req_level; // requested duty as high steps, clamped
    logic [9:0] next_level; // level to load at the next boundary
    logic [4:0] next_code; // code to load at the next boundary

    // requested setting decoded into high-step count
    always_comb begin
        req_ceiling = duty_ceiling(pwm_setting.code);
        req_over = pwm_setting.duty > req_ceiling;
        if (req_over) begin
            req_level = req_ceiling; // clamp to maximum
        end else begin
            req_level = pwm_setting.duty;
        end
        if (is_coarse(pwm_setting.code)) begin
            // whole percent, finer digits rounded off
            req_level = 10'((req_level + COARSE_ROUND) / COARSE_UNIT);
        end
    end

    // a start needs configuration, the enable, a legal code and duty
    assign start_ok = channel_configured_pwm && en_sync && code_ok(pwm_setting.code)
        && !req_over;
    assign keep_on = channel_configured_pwm && en_sync;

    // an illegal code while running keeps the old code and its level
    always_comb begin
        if (code_ok(pwm_setting.code)) begin
            next_code = pwm_setting.code;
            next_level = req_level;
        end else begin
            next_code = act_code;
            next_level = act_level;
        end
    end

    // channel state machine
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= CFPWM_IDLE;
        end else begin
            case (state)
                CFPWM_IDLE: begin
                    if (pwm_start_command && start_ok) begin
                        state <= CFPWM_RUN;
                    end
                end
                CFPWM_RUN: begin
                    if (!keep_on) begin
                        state <= CFPWM_IDLE; // output stops with the enable
                    end
                end
                default: begin
                    state <= CFPWM_IDLE;
                end
            endcase
        end
    end

    // settings load on start and otherwise only at a period boundary
    always_ff @(posedge clk) begin
        if (srst) begin
            act_code <= 5'h00;
            act_level <= 10'h000;
        end else if (state == CFPWM_IDLE && pwm_start_command && start_ok) begin
            act_code <= pwm_setting.code;
            act_level <= req_level;
        end else if (state == CFPWM_RUN && boundary) begin
            act_code <= next_code;
            act_level <= next_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // period timing

    assign act_steps = is_coarse(act_code) ? STEPS_COARSE : STEPS_FINE;
    assign step_tick = (pre_cnt == '0);
    assign boundary = step_tick && (step_cnt == act_steps - 10'h001);

    // prescaler: reloads from the per-code table, so frequency follows code
    // while idle it tracks the requested code, so the first step of a start
    // already has the started code's length instead of the slowest one
    always_ff @(posedge clk) begin
        if (srst) begin
            pre_cnt <= PRE_W'(STEP_CYCLES[0] - 1);
        end else if (state != CFPWM_RUN) begin
            pre_cnt <= PRE_W'(STEP_CYCLES[next_code] - 1);
        end else if (step_tick) begin
            if (boundary) begin
                pre_cnt <= PRE_W'(STEP_CYCLES[next_code] - 1);
            end else begin
                pre_cnt <= PRE_W'(STEP_CYCLES[act_code] - 1);
            end
        end else begin
            pre_cnt <= pre_cnt - PRE_W'(1);
        end
    end

    // start: the first run cycle holds the pin low and clears the step count
    // the prescaler already holds the started code's reload from idle
    logic first_load; // set for the cycle after a start

    always_ff @(posedge clk) begin
        if (srst) begin
            first_load <= 1'b0;
        end else begin
            first_load <= (state == CFPWM_IDLE) && pwm_start_command && start_ok;
        end
    end

    // step counter within one period
    always_ff @(posedge clk) begin
        if (srst || state != CFPWM_RUN || first_load) begin
            step_cnt <= 10'h000;
        end else if (boundary) begin
            step_cnt <= 10'h000;
        end else if (step_tick) begin
            step_cnt <= step_cnt + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // pin high for the first act_level steps of each period
    always_ff @(posedge clk) begin
        if (srst) begin
            pwm_output_pin <= 1'b0;
        end else if (state == CFPWM_RUN && keep_on && !first_load) begin
            pwm_output_pin <= (step_cnt < act_level);
        end else begin
            pwm_output_pin <= 1'b0;
        end
    end

    // status flags; error pulses once per refused start
    always_ff @(posedge clk) begin
        if (srst) begin
            pwm_running <= 1'b0;
            operation_error <= 1'b0;
            duty_clamped <= 1'b0;
        end else begin
            pwm_running <= (state == CFPWM_RUN) && keep_on;
            operation_error <= (state == CFPWM_IDLE) && pwm_start_command
                && !start_ok;
            duty_clamped <= (state == CFPWM_RUN) && req_over;
        end
    end

endmodule : cfpwm_channel

`default_nettype wire

//--- sim/cfpwm_assertions.sv
// assertions on the pwm channel ports
// assumes one clock and a synchronous reset
`default_nettype none
module cfpwm_assertions
    import cfpwm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic pwm_enable_input,
    input wire logic channel_configured_pwm,
    input wire logic pwm_start_command,
    input wire cfpwm_setting_type pwm_setting,
    input wire logic pwm_output_pin,
    input wire logic pwm_running,
    input wire logic operation_error,
    input wire logic duty_clamped
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // legal pair on a full-speed channel
    function automatic bit legal(input cfpwm_setting_type s);
        return (s.code <= CODE_MAX) && (s.duty <= ((s.code >= CODE_COARSE_FIRST) ?
            DUTY_MAX_COARSE : DUTY_MAX_FINE));
    endfunction : legal
    // steady long enough to pass the enable synchroniser
    sequence s_ready;
        (channel_configured_pwm && pwm_enable_input) [*3];
    endsequence
    // a pulse just before may already be in flight, so skip those
    sequence s_fresh;
        pwm_start_command && !pwm_running && !$past(pwm_start_command);
    endsequence
    property p_accept;
        s_ready ##0 s_fresh ##0 legal(pwm_setting) ##1 channel_configured_pwm [*2] |-> pwm_running;
    endproperty
    a_accept: assert property (p_accept) else $error("start not run");
    property p_refuse;
        s_ready ##0 s_fresh ##0 !legal(pwm_setting) |=> operation_error;
    endproperty
    a_refuse: assert property (p_refuse) else $error("start not refused");
    property p_err_once;
        operation_error |=> !operation_error;
    endproperty
    a_err_once: assert property (p_err_once) else $error("error too long");
    property p_err_cause;
        operation_error |-> $past(pwm_start_command) && !$past(pwm_running);
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("error uncaused");
    property p_keep;
        s_ready ##0 pwm_running |=> pwm_running;
    endproperty
    a_keep: assert property (p_keep) else $error("run dropped");
    property p_en_stop;
        !pwm_enable_input [*4] |-> !pwm_running && !pwm_output_pin;
    endproperty
    a_en_stop: assert property (p_en_stop) else $error("no stop on enable");
    property p_cfg_stop;
        !channel_configured_pwm [*3] |-> !pwm_running && !pwm_output_pin;
    endproperty
    a_cfg_stop: assert property (p_cfg_stop) else $error("no stop on config");
    property p_idle_pin;
        !pwm_running [*2] |-> !pwm_output_pin;
    endproperty
    a_idle_pin: assert property (p_idle_pin) else $error("pin while idle");
    property p_clamp;
        duty_clamped |-> $past(pwm_setting.duty) > DUTY_MAX_COARSE;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp uncaused");
endmodule : cfpwm_assertions
bind cfpwm_channel cfpwm_assertions cfpwm_assertions_inst (.clk(clk), .srst(srst),
    .pwm_enable_input(pwm_enable_input), .channel_configured_pwm(channel_configured_pwm),
    .pwm_start_command(pwm_start_command), .pwm_setting(pwm_setting),
    .pwm_output_pin(pwm_output_pin), .pwm_running(pwm_running),
    .operation_error(operation_error), .duty_clamped(duty_clamped));
`default_nettype wire

//--- sim/cfpwm_load_model.sv
// load on the pwm pin: integrates high time, counts pulses
// assumes the channel clock; the load never drives back
`default_nettype none
module cfpwm_load_model (
    input wire logic clk,
    input wire logic pwm_output_pin,
    output int high_total,
    output int rise_total
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev = 1'b0; // last pin level
    int high_cnt = 0; // clocks seen high
    int rise_cnt = 0; // rising edges seen
    // one driver per port: the counters live here, the ports only show them
    assign high_total = high_cnt;
    assign rise_total = rise_cnt;
    // an unknown pin counts as low, so it shows as a mismatch
    always @(posedge clk) begin
        high_cnt <= high_cnt + int'(pwm_output_pin === 1'b1);
        rise_cnt <= rise_cnt + int'(pwm_output_pin === 1'b1 && !prev);
        prev <= (pwm_output_pin === 1'b1);
    end
endmodule : cfpwm_load_model
`default_nettype wire

//--- sim/cfpwm_tb.sv
// self-checking bench for the pwm channel
// assumes a full-speed channel and the load model on its pin
`default_nettype none
module testbench
    import cfpwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic en = 1'b0; // enable pin
    logic cfg = 1'b0; // channel set to pwm
    logic start = 1'b0;
    cfpwm_setting_type set = '0;
    logic pin, run, err, clamp;
    int high_total, rise_total;
    int fails = 0;
    int cmp_count = 0;
    int seed = 32'h8eed;
    int d; // duty under test
    cfpwm_channel cfpwm_channel_inst (.clk(clk), .srst(srst), .pwm_enable_input(en),
        .channel_configured_pwm(cfg), .pwm_start_command(start), .pwm_setting(set),
        .pwm_output_pin(pin), .pwm_running(run), .operation_error(err), .duty_clamped(clamp));
    cfpwm_load_model cfpwm_load_model_inst (.clk(clk), .pwm_output_pin(pin),
        .high_total(high_total), .rise_total(rise_total));
    always #10 clk = ~clk;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
            fails++;
        end
    endtask : check
    function automatic int step_of(input int c);
        return PERIOD_10US[c] * 10000 / (CLK_PERIOD_NS * ((c >= 20) ? 100 : 1000));
    endfunction : step_of
    // coarse codes clamp first, then round to whole percent
    function automatic int high_of(input int c, input int dt);
        if (c >= 20) return ((dt > 990 ? 990 : dt) + 5) / 10 * step_of(c);
        return (dt > 999 ? 999 : dt) * step_of(c);
    endfunction : high_of
    task automatic start_pwm(input int c, input int dt, input logic ok);
        set = {c[4:0], dt[9:0]};
        start = 1'b1;
        tick(1);
        start = 1'b0;
        check("error", !ok, err);
        tick(1);
        check("running", ok, run);
        check("error end", 0, err);
    endtask : start_pwm
    // one whole period after settling holds the exact high time
    task automatic measure(input int c, input int dt);
        int h0;
        int r0;
        int per;
        per = step_of(c) * ((c >= 20) ? 100 : 1000);
        tick(per + 4);
        h0 = high_total;
        r0 = rise_total;
        tick(per);
        check("high time", high_of(c, dt), high_total - h0);
        check("pulses", high_of(c, dt) != 0, rise_total - r0);
        check("kept running", 1, run);
    endtask : measure
    task automatic stop_check();
        en = 1'b0;
        tick(4);
        check("stopped", 0, {run, pin});
        en = 1'b1;
        tick(3);
    endtask : stop_check
    task automatic end_sim();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    initial begin
        tick(4);
        srst = 1'b0;
        check("reset", 0, {pin, run, err, clamp});
        en = 1'b1;
        cfg = 1'b1;
        tick(3);
        // codes stay at 24 or below on this full-speed channel
        for (int c = 18; c <= 24; c++) begin
            d = $unsigned($random(seed)) % ((c >= 20) ? 991 : 1000);
            d = (c == 19) ? 999 : (c == 20) ? 990 : d;
            start_pwm(c, d, 1'b1);
            measure(c, d);
            stop_check();
        end
        $display("test ranges done");
        start_pwm(24, 300, 1'b1);
        set.duty = 10'h007;
        measure(24, 7);
        set.duty = 10'h3ff;
        measure(24, 1023);
        check("clamped", 1, clamp);
        stop_check();
        $display("test running changes done");
        start_pwm(24, 991, 1'b0);
        start_pwm(19, 1000, 1'b0);
        start_pwm(25, 0, 1'b0);
        cfg = 1'b0;
        start_pwm(24, 500, 1'b0);
        cfg = 1'b1;
        start_pwm(24, 500, 1'b1);
        cfg = 1'b0;
        tick(3);
        check("config drop", 0, {run, pin});
        $display("test refusals done");
        end_sim();
    end
    // watchdog: the whole run needs about 48k cycles, this allows 80k
    initial begin
        #1600000;
        fails++;
        end_sim();
    end
endmodule : testbench
`default_nettype wire
